// ===== rtl/sfx_defines.svh
// constants of the serial flash execute-in-place host controller
`ifndef SFX_DEFINES_SVH
`define SFX_DEFINES_SVH

// register byte offsets on the avalon slave
`define SFX_REG_CTRL        4'h0
`define SFX_REG_ADDR        4'h4
`define SFX_REG_STATUS      4'h8

// control register fields
`define SFX_CTRL_OP_LSB     0
`define SFX_CTRL_OP_MSB     2
`define SFX_CTRL_CONFIRM    3
`define SFX_CTRL_XIP_KNOWN  4
`define SFX_CTRL_BYTE_LSB   8
`define SFX_CTRL_BYTE_MSB   15

// status register fields
`define SFX_ST_BUSY         0
`define SFX_ST_POLL_OK      1
`define SFX_ST_FULL_OK      2
`define SFX_ST_XIP          3
`define SFX_ST_PE_READY     4
`define SFX_ST_REFUSED      5
`define SFX_ST_DATA_LSB     8

// flash command codes
`define SFX_CODE_RST_EN     8'h66
`define SFX_CODE_RST_MEM    8'h99
`define SFX_CODE_FAST_READ  8'h0B
`define SFX_CODE_WR_EN      8'h06
`define SFX_CODE_WR_VCFG    8'h81
`define SFX_CODE_RD_FLAG    8'h70
`define SFX_CODE_ALL_ONES   8'hFF
`define SFX_VCFG_XIP_BIT    3
`define SFX_FLAG_READY_BIT  7

// timing, clock 10 MHz
`define SFX_CLK_PERIOD_NS   100
`define SFX_T_POLL_US       100
`define SFX_T_FULL_US       150
`define SFX_T_GAP_NS        50
`define SFX_POLL_CYC        ((`SFX_T_POLL_US * 1000) / `SFX_CLK_PERIOD_NS)
`define SFX_FULL_CYC        ((`SFX_T_FULL_US * 1000) / `SFX_CLK_PERIOD_NS)
`define SFX_GAP_CYC         ((`SFX_T_GAP_NS + `SFX_CLK_PERIOD_NS - 1) / `SFX_CLK_PERIOD_NS)
`define SFX_DUMMY_CLKS      8
`define SFX_HALF_BIT        4

`endif

// ===== rtl/sfx_pkg.sv
// types of the serial flash execute-in-place host controller
package sfx_pkg;

  typedef enum logic [2:0] {
    SFX_OP_NONE,
    SFX_OP_CMD,
    SFX_OP_ARM,
    SFX_OP_XIP_READ,
    SFX_OP_POLL,
    SFX_OP_RESYNC,
    SFX_OP_RECOVER
  } sfx_op_type;

  // one select-low segment of a sequence
  typedef struct packed {
    logic        last;
    logic [5:0]  nclk;
    logic [47:0] tx;
  } sfx_seg_type;

  // pins driven toward the flash
  typedef struct packed {
    logic       sel_n;
    logic       sclk;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } sfx_pins_type;

endpackage

// ===== rtl/sfx_host.sv
// host controller that sequences a serial flash through xip, polling and recovery
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`include "sfx_defines.svh"

module sfx_host
  import sfx_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic [3:0]   flash_io_in,
  output sfx_pins_type      flash_pins
);

  typedef enum logic [1:0] {
    SFX_ST_IDLE,
    SFX_ST_GAP,
    SFX_ST_SHIFT
  } sfx_state_type;

  // length of burst n of the resync and recovery sequences
  function automatic logic [5:0] burst_len(input logic [3:0] idx);
    case (idx)
      4'h0:    burst_len = 6'h07;
      4'h1:    burst_len = 6'h09;
      4'h2:    burst_len = 6'h0D;
      4'h3:    burst_len = 6'h11;
      4'h4:    burst_len = 6'h19;
      default: burst_len = 6'h21;
    endcase
  endfunction

  // segment table: what one select-low period sends for each step of an operation
  function automatic sfx_seg_type seg_of(input sfx_op_type  op,
                                         input logic [3:0]  idx,
                                         input logic [23:0] addr,
                                         input logic [7:0]  cfg,
                                         input logic        confirm,
                                         input logic        in_xip);
    sfx_seg_type s;
    logic [7:0]  vcfg;
    s      = '{last: 1'b1, nclk: 6'h08, tx: {6{`SFX_CODE_ALL_ONES}}};
    vcfg   = cfg;
    vcfg[`SFX_VCFG_XIP_BIT] = 1'b0;
    case (op)
      SFX_OP_CMD: begin
        s.tx = {cfg, {5{`SFX_CODE_ALL_ONES}}};
      end
      SFX_OP_ARM: begin
        if (idx == 4'h0) begin
          s.last = 1'b0;
          s.tx   = {`SFX_CODE_WR_EN, {5{`SFX_CODE_ALL_ONES}}};
        end else begin
          s.nclk = 6'h10;
          s.tx   = {`SFX_CODE_WR_VCFG, vcfg, {4{`SFX_CODE_ALL_ONES}}};
        end
      end
      SFX_OP_XIP_READ: begin
        // confirm bit leads the dummy field, io 2 and 3 stay driven high, io 1 is not driven
        if (in_xip) begin
          s.nclk = 6'h28;
          s.tx   = {addr, confirm, 7'h7F, {2{`SFX_CODE_ALL_ONES}}};
        end else begin
          s.nclk = 6'h30;
          s.tx   = {`SFX_CODE_FAST_READ, addr, confirm, 7'h7F,
                    `SFX_CODE_ALL_ONES};
        end
      end
      SFX_OP_POLL: begin
        s.last = (idx == 4'h1);
        s.nclk = 6'h10;
        s.tx   = {`SFX_CODE_RD_FLAG, {5{`SFX_CODE_ALL_ONES}}};
      end
      SFX_OP_RESYNC: begin
        s.last = (idx == 4'h7);
        if (idx < 4'h6) begin
          s.nclk = burst_len(idx);
        end else if (idx == 4'h6) begin
          s.tx   = {`SFX_CODE_RST_EN, {5{`SFX_CODE_ALL_ONES}}};
        end else begin
          s.tx   = {`SFX_CODE_RST_MEM, {5{`SFX_CODE_ALL_ONES}}};
        end
      end
      SFX_OP_RECOVER: begin
        // bursts first, all-ones byte last: the order is fixed by the index
        s.last = (idx == 4'h6);
        if (idx < 4'h6) begin
          s.nclk = burst_len(idx);
        end                                                      // else
      end
      default: begin
        s.last = 1'b1;
      end
    endcase
    seg_of = s;
  endfunction

  // input synchroniser flops
  logic [3:0]    io_meta_q;
  logic [3:0]    io_sync_q;
  // bus slave state
  logic          wait_q, wait_d;
  logic [31:0]   rdata_q, rdata_d;

  // sequencer state
  sfx_state_type state_q, state_d;
  sfx_op_type    op_q, op_d;
  logic [3:0]    idx_q, idx_d;
  logic [2:0]    cnt_q, cnt_d;
  logic [5:0]    left_q, left_d;
  logic [47:0]   tx_q, tx_d;
  logic [7:0]    rx_q, rx_d;
  logic [7:0]    data_q, data_d;
  logic          sel_n_q, sel_n_d;
  logic          sclk_q, sclk_d;
  logic [23:0]   addr_q, addr_d;
  logic [7:0]    cfg_q, cfg_d;
  logic          confirm_q, confirm_d;
  logic          xip_q, xip_d;
  logic          ready_q, ready_d;
  logic          refused_q, refused_d;
  logic [10:0]   up_cnt_q, up_cnt_d;
  logic          poll_ok_q, poll_ok_d;
  logic          full_ok_q, full_ok_d;
  logic [1:0]    gap_q, gap_d;
  sfx_seg_type   seg;
  sfx_op_type    wr_op;
  logic          wr_ctrl;
  logic          op_allowed;
  logic          busy;
  // io lines cross from the flash into our clock: two flops, only the second reads the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_meta_q <= 4'h0;
      io_sync_q <= 4'h0;
    end else begin
      io_meta_q <= flash_io_in;
      io_sync_q <= io_meta_q;
    end
  end
  assign busy    = (state_q != SFX_ST_IDLE);
  assign seg     = seg_of(op_q, idx_q, addr_q, cfg_q, confirm_q, xip_q);
  assign wr_op   = sfx_op_type'(avs_writedata[`SFX_CTRL_OP_MSB:`SFX_CTRL_OP_LSB]);
  assign wr_ctrl = avs_write && !wait_q && (avs_address == `SFX_REG_CTRL);
  // polling may start earlier than everything else after power-up
  always_comb begin
    if (wr_op == SFX_OP_POLL) begin
      op_allowed = poll_ok_q;
    end else begin
      op_allowed = full_ok_q;
    end
  end
  // next values of bus slave and sequencer
  always_comb begin
    wait_d    = 1'b1;
    rdata_d   = rdata_q;
    state_d   = state_q;
    op_d      = op_q;
    idx_d     = idx_q;
    cnt_d     = cnt_q;
    left_d    = left_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    data_d    = data_q;
    sel_n_d   = sel_n_q;
    sclk_d    = sclk_q;
    addr_d    = addr_q;
    cfg_d     = cfg_q;
    confirm_d = confirm_q;
    xip_d     = xip_q;
    ready_d   = ready_q;
    refused_d = refused_q;
    up_cnt_d  = up_cnt_q;
    poll_ok_d = poll_ok_q;
    full_ok_d = full_ok_q;
    gap_d     = gap_q;

    // power-up windows counted from our reset release
    if (!full_ok_q) begin
      up_cnt_d = up_cnt_q + 11'h001;
    end
    if (up_cnt_q == 11'(`SFX_POLL_CYC)) begin
      poll_ok_d = 1'b1;
    end
    if (up_cnt_q == 11'(`SFX_FULL_CYC)) begin
      full_ok_d = 1'b1;
    end

    // one wait cycle per access, then the answer stands for one edge
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      case (avs_address)
        `SFX_REG_CTRL:   rdata_d = {16'h0000, cfg_q, 4'h0, confirm_q, op_q};
        `SFX_REG_ADDR:   rdata_d = {8'h00, addr_q};
        `SFX_REG_STATUS: rdata_d = {16'h0000, data_q, 2'b00, refused_q, ready_q,
                                    xip_q, full_ok_q, poll_ok_q, busy};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end

    if (avs_write && !wait_q && (avs_address == `SFX_REG_ADDR) && !busy) begin
      addr_d = avs_writedata[23:0];
    end

    // a new order is refused while busy or before its power-up window
    if (wr_ctrl) begin
      if (busy || (wr_op != SFX_OP_NONE && !op_allowed)) begin
        refused_d = 1'b1;
      end else begin
        refused_d = 1'b0;
        cfg_d     = avs_writedata[`SFX_CTRL_BYTE_MSB:`SFX_CTRL_BYTE_LSB];
        confirm_d = avs_writedata[`SFX_CTRL_CONFIRM];
        if (avs_writedata[`SFX_CTRL_XIP_KNOWN]) begin
          xip_d = 1'b1;
        end
        if (wr_op != SFX_OP_NONE) begin
          op_d    = wr_op;
          idx_d   = 4'h0;
          gap_d   = 2'(`SFX_GAP_CYC);
          state_d = SFX_ST_GAP;
          if (wr_op == SFX_OP_POLL) begin
            ready_d = 1'b1;
          end
        end
      end
    end

    case (state_q)
      SFX_ST_IDLE: begin
        sel_n_d = 1'b1;
        sclk_d  = 1'b0;
      end
      SFX_ST_GAP: begin
        // select stays high at least the minimum deselect gap
        if (gap_q > 2'd1) begin
          gap_d = gap_q - 2'd1;
        end else begin
          sel_n_d = 1'b0;
          tx_d    = seg.tx;
          left_d  = seg.nclk;
          cnt_d   = 3'd0;
          state_d = SFX_ST_SHIFT;
        end
      end
      SFX_ST_SHIFT: begin
        cnt_d  = cnt_q + 3'd1;
        sclk_d = (cnt_d >= 3'(`SFX_HALF_BIT));
        if (cnt_q == 3'd7) begin
          // sample late in the high half, the device changes data after falling edge
          rx_d   = {rx_q[6:0], io_sync_q[1]};
          tx_d   = {tx_q[46:0], 1'b1};
          left_d = left_q - 6'd1;
          if (left_q == 6'd1) begin
            // select rises before any further clock edge
            sel_n_d = 1'b1;
            data_d  = rx_d;
            gap_d   = 2'(`SFX_GAP_CYC);
            if (op_q == SFX_OP_POLL) begin
              ready_d = ready_q & rx_d[`SFX_FLAG_READY_BIT];
            end
            if (op_q == SFX_OP_XIP_READ) begin
              xip_d = !confirm_q;
            end
            if (op_q == SFX_OP_RESYNC || op_q == SFX_OP_RECOVER) begin
              xip_d = 1'b0;
            end
            if (seg.last) begin
              state_d = SFX_ST_IDLE;
            end else begin
              idx_d   = idx_q + 4'h1;
              state_d = SFX_ST_GAP;
            end
          end
        end
      end
      default: begin
        state_d = SFX_ST_IDLE;
      end
    endcase
  end
  // registers of bus slave and sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q    <= 1'b1;
      rdata_q   <= 32'h0000_0000;
      state_q   <= SFX_ST_IDLE;
      op_q      <= SFX_OP_NONE;
      idx_q     <= 4'h0;
      cnt_q     <= 3'd0;
      left_q    <= 6'h00;
      tx_q      <= {48{1'b1}};
      rx_q      <= 8'h00;
      data_q    <= 8'h00;
      sel_n_q   <= 1'b1;
      sclk_q    <= 1'b0;
      addr_q    <= 24'h00_0000;
      cfg_q     <= 8'h00;
      confirm_q <= 1'b1;
      xip_q     <= 1'b0;
      ready_q   <= 1'b0;
      refused_q <= 1'b0;
      up_cnt_q  <= 11'h000;
      poll_ok_q <= 1'b0;
      full_ok_q <= 1'b0;
      gap_q     <= 2'd0;
    end else begin
      wait_q    <= wait_d;
      rdata_q   <= rdata_d;
      state_q   <= state_d;
      op_q      <= op_d;
      idx_q     <= idx_d;
      cnt_q     <= cnt_d;
      left_q    <= left_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      data_q    <= data_d;
      sel_n_q   <= sel_n_d;
      sclk_q    <= sclk_d;
      addr_q    <= addr_d;
      cfg_q     <= cfg_d;
      confirm_q <= confirm_d;
      xip_q     <= xip_d;
      ready_q   <= ready_d;
      refused_q <= refused_d;
      up_cnt_q  <= up_cnt_d;
      poll_ok_q <= poll_ok_d;
      full_ok_q <= full_ok_d;
      gap_q     <= gap_d;
    end
  end
  // io 0 carries serial data, io 2 and 3 held high, io 1 left to the flash
  assign flash_pins.sel_n  = sel_n_q;
  assign flash_pins.sclk   = sclk_q;
  assign flash_pins.io_out = {2'b11, 1'b0, tx_q[47]};
  assign flash_pins.io_oe  = 4'b1101;
  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
endmodule

// ===== test/sfx_chk_sva.sv
// assertion checker on the flash link pins of the xip host controller
`include "sfx_defines.svh"
module sfx_chk
  import sfx_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire sfx_pins_type flash_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] up_q;
  logic [10:0] up_d;
  logic [1:0]  hi_q;
  logic [1:0]  hi_d;

  // cycles since release, stops at the polling window; deselect length, saturating
  always_comb begin
    up_d = (up_q < 11'h3E8) ? up_q + 11'h001 : up_q;
    hi_d = !flash_pins.sel_n ? 2'h0 : ((hi_q == 2'h3) ? hi_q : hi_q + 2'h1);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 11'h000;
      hi_q <= 2'h0;
    end else begin
      up_q <= up_d;
      hi_q <= hi_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // one serial bit is four cycles low then four high
  sequence s_low4;
    !flash_pins.sclk [*4] ##1 flash_pins.sclk;
  endsequence
  sequence s_high4;
    flash_pins.sclk [*4] ##1 !flash_pins.sclk;
  endsequence

  AST_POWERUP_QUIET: assert property (up_q < 11'h3E8 |-> flash_pins.sel_n)
    else $error("flash selected before polling window");
  AST_GAP_MIN: assert property ($fell(flash_pins.sel_n) |-> hi_q >= 2'(`SFX_GAP_CYC))
    else $error("deselect gap shorter than minimum");
  AST_CLK_STILL: assert property (flash_pins.sel_n |-> !flash_pins.sclk)
    else $error("serial clock high while deselected");
  AST_FIRST_BIT: assert property ($fell(flash_pins.sel_n) |-> s_low4)
    else $error("first bit low phase wrong");
  AST_HIGH_PHASE: assert property ($rose(flash_pins.sclk) |-> s_high4)
    else $error("serial clock high phase not four cycles");
  AST_IO0_HELD: assert property (!flash_pins.sel_n && flash_pins.sclk |->
    $stable(flash_pins.io_out[0])) else $error("io0 moved during clock high");
  AST_HOLD_HIGH: assert property (flash_pins.io_oe[3] && flash_pins.io_out[3])
    else $error("io3 not driven high");
  AST_IO1_FREE: assert property (!flash_pins.io_oe[1])
    else $error("host drives io1");
endmodule

bind sfx_host sfx_chk sfx_chk_inst (.clk(clk), .resetn(resetn), .flash_pins(flash_pins));

// ===== test/sfx_flash_model.sv
// behavioural serial flash answering the host on the extended protocol
module sfx_flash_model
  import sfx_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         boot_xip,
  input wire logic         pe_busy,
  input wire sfx_pins_type pins,
  output logic             io1,
  output logic             dev_xip,
  output logic [7:0]       dev_cfg,
  output logic [7:0]       dev_cmd,
  output logic [7:0]       dev_rsts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [47:0] sr;
  logic [5:0]  n;
  logic [5:0]  dst;
  logic [7:0]  dout;
  logic        sp;
  logic        drv;
  logic        rst_en;
  // armed variant modelled; a basic-xip part would enter on any fast read with the confirm bit low
  localparam bit BASIC_XIP = 1'b0;

  // sclk is sampled on the system clock; io1 toggles whenever released
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin // pulse while deselected: power-up state
      dev_xip <= boot_xip;
      dev_cfg <= 8'hFF;
      dev_cmd <= 8'h00;
      dev_rsts <= 8'h00;
      {sr, n, dst, dout, sp, drv, rst_en, io1} <= '0;
    end else begin
      sp <= pins.sclk;
      if (!drv) io1 <= ~io1;
      if (pins.sel_n) begin
        n <= 6'h00;
        dst <= 6'h00;
        drv <= 1'b0;
        if (n == 6'h08) begin
          dev_cmd <= sr[7:0]; // any code alone, no write enable
          rst_en <= (sr[7:0] == 8'h66);
          if (rst_en && sr[7:0] == 8'h99) begin // two-step reset
            dev_xip <= boot_xip;
            dev_cfg <= 8'hFF;
            dev_rsts <= dev_rsts + 8'h01;
          end
        end
        if (n == 6'h10 && sr[15:8] == 8'h81) dev_cfg <= sr[7:0];
      end else if (pins.sclk && !sp) begin
        sr <= {sr[46:0], pins.io_out[0]};
        n <= n + 6'h01;
        // confirm bit on first dummy rise, address only in xip
        if (dev_xip ? n == 6'h18 : (n == 6'h20 && sr[31:24] == 8'h0B)) begin
          if (dev_xip || !dev_cfg[3] || BASIC_XIP) dev_xip <= !pins.io_out[0];
          if (pins.io_out[0]) dev_cfg[3] <= 1'b1;
          dout <= sr[7:0] ^ 8'h5A;
          dst <= n + 6'h08;
        end
        if (n + 6'h01 == dst) drv <= 1'b1;
        if (n == 6'h07 && !dev_xip && {sr[6:0], pins.io_out[0]} == 8'h70) begin
          dout <= {!pe_busy, 7'h00};
          drv <= 1'b1;
        end
      end else if (!pins.sclk && sp && drv) begin
        io1 <= dout[7];
        dout <= {dout[6:0], 1'b0};
      end
    end
  end
endmodule

// ===== test/test_sfx_host.sv
// self-checking bench for the xip host controller against a flash model
module test_sfx_host;
  import sfx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic         io1, dev_xip, pe_busy, boot_xip;
  logic         sp = 1'b0;
  logic         sl = 1'b1;
  logic [3:0]   avs_address, io_in;
  logic [31:0]  avs_writedata, avs_readdata, st;
  logic [7:0]   dev_cfg, dev_cmd, dev_rsts;
  logic [63:0]  sh = 64'h0;
  sfx_pins_type pins;
  int           miscompares = 0, n_compared = 0, cyc = 0, cnt = 0;
  int           fl[$];
  logic [63:0]  fs[$];
  int           b[6] = '{7, 9, 13, 17, 25, 33};

  // idle lines float high, io1 comes from the flash
  assign io_in = (pins.io_oe & pins.io_out) | (~pins.io_oe & {2'b11, io1, 1'b1});

  sfx_host sfx_host_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_io_in(io_in), .flash_pins(pins));
  sfx_flash_model sfx_flash_model_inst (.clk(clk), .resetn(resetn), .boot_xip(boot_xip),
    .pe_busy(pe_busy), .pins(pins), .io1(io1), .dev_xip(dev_xip), .dev_cfg(dev_cfg),
    .dev_cmd(dev_cmd), .dev_rsts(dev_rsts));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // frame monitor: clocks and io0 bits of each select-low period
  always @(posedge clk) begin
    cyc <= resetn ? cyc + 1 : 0;
    sp <= pins.sclk;
    sl <= pins.sel_n;
    if (!pins.sel_n && pins.sclk && !sp) begin
      cnt <= cnt + 1;
      sh <= {sh[62:0], pins.io_out[0]};
    end
    if (pins.sel_n && !sl) begin
      fl.push_back(cnt);
      fs.push_back(sh);
      cnt <= 0;
      sh <= 64'h0;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wait_idle;
    bus(1'b0, 4'h8, 32'h0);
    while (st[0] !== 1'b0) bus(1'b0, 4'h8, 32'h0);
  endtask

  task op(input logic [31:0] w);
    fl.delete();
    fs.delete();
    bus(1'b1, 4'h0, w);
    wait_idle;
  endtask

  task fr(input int n, input int k);
    chk(32'(fl[k]), 32'(n));
  endtask

  task bursts;
    for (int i = 0; i < 6; i++) begin
      fr(b[i], i);
      chk({31'h0, fs[i] === (64'h1 << b[i]) - 64'h1}, 32'h1);
    end
  endtask

  task s_power;
    chk({29'h0, pins.sel_n, pins.sclk, avs_waitrequest}, 32'h5);
    chk(avs_readdata, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(st[2:0], 3'h0);
    op(32'h4);
    chk(st[5], 1'b1);
    bus(1'b0, 4'hC, 32'h0);
    chk(st, 32'h0);
    while (cyc < 1005) @(posedge clk);
    op(32'h2);
    chk(st[5:1], 5'h11);
    pe_busy <= 1'b1;
    op(32'h4);
    fr(16, 0);
    fr(16, 1);
    chk(st[5:4], 2'h0);
    while (cyc < 1505) @(posedge clk);
    pe_busy <= 1'b0;
    op(32'h4);
    chk({st[15:8], st[4]}, 9'h101);
  endtask

  task s_xip;
    op(32'h3501);
    chk({dev_cmd, 24'(fl.size())}, 32'h35000001);
    bus(1'b0, 4'h0, 32'h0);
    chk(st, 32'h3501);
    op(32'hFF02);
    fr(16, 1);
    chk(dev_cfg, 8'hF7);
    bus(1'b1, 4'h4, 32'hABCD);
    bus(1'b0, 4'h4, 32'h0);
    chk(st, 32'hABCD);
    op(32'h3);
    fr(48, 0);
    chk({st[15:8], st[3], dev_xip}, {8'hCD ^ 8'h5A, 2'b11});
    bus(1'b1, 4'h4, 32'h12);
    fl.delete();
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b1, 4'h0, 32'h4);
    wait_idle;
    chk(st[5], 1'b1);
    fr(40, 0);
    chk(st[15:8], 8'h12 ^ 8'h5A);
    op(32'hB);
    fr(40, 0);
    chk({st[3], dev_xip, dev_cfg[3]}, 3'b001);
  endtask

  task s_resync;
    op(32'hFF02);
    op(32'h3);
    chk(dev_xip, 1'b1);
    op(32'h5);
    bursts;
    chk({fs[6][7:0], fs[7][7:0], 8'(fl.size())}, 24'h669908);
    chk({st[3], dev_xip, dev_rsts}, 10'h001);
    op(32'h6);
    bursts;
    chk({fs[6][7:0], 8'(fl[6]), 8'(fl.size()), dev_cmd}, 32'hFF0807FF);
  endtask

  task s_boot;
    resetn <= 1'b0;
    boot_xip <= 1'b1;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    while (cyc < 1505) @(posedge clk);
    bus(1'b1, 4'h0, 32'h10);
    bus(1'b1, 4'h4, 32'h56);
    op(32'hB);
    fr(40, 0);
    chk({st[15:8], dev_xip}, {8'h56 ^ 8'h5A, 1'b0});
  endtask

  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata, pe_busy, boot_xip} = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    s_power;
    s_xip;
    s_resync;
    s_boot;
    wrap_up;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule
